// >>> hw/error_status_params.svh
/*
  constants for the sticky error status bank: register offsets,
  field positions, reset values and duty thresholds.
  assumes it is included by bare name wherever a number is needed.
*/
`ifndef ERROR_STATUS_PARAMS_SVH
`define ERROR_STATUS_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADDR_THROTTLE_STATUS  8'h44
`define ADDR_INPUT_STATUS     8'h46
`define ADDR_FAN_STATUS       8'h47
`define ADDR_THROTTLE_LIMIT   8'h50
`define ADDR_SLEEP_STATE      8'h51
`define ADDR_SLEEP_MASK       8'h52
`define ADDR_INPUT_MASK       8'h53
`define ADDR_SUMMARY          8'h54

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define STATUS_RESET          8'h00
`define LIMIT_RESET           8'hff
`define FAN_CHANNELS          4
`define INPUT_PINS            8
`define THROTTLE_BITS         8
`define THROTTLE_LIMIT_BIT    7
`define MASK_INPUT_S1         0
`define MASK_INPUT_S3         1
`define MASK_INPUT_S45        2
`define MASK_FAN_S1           3
`define MASK_FAN_S3           4
`define MASK_USED_BITS        5'h1f
`define SUMMARY_HOST_BIT      0
`define SUMMARY_MGMT_BIT      1

// ---------------------------------------------------------------
// duty window: 256 samples, one sample is 0.39 %
// ---------------------------------------------------------------
`define DUTY_WINDOW           9'h100
`define DUTY_12P5             9'h020
`define DUTY_25               9'h040
`define DUTY_50               9'h080
`define DUTY_75               9'h0c0
`define SAMPLE_PERIOD_NS      1000
`define CLK_PERIOD_NS         20

`endif

// >>> hw/error_status_pkg.sv
/*
  types shared by the error status bank modules.
  assumes nothing beyond a SystemVerilog compiler.
*/
package error_status_pkg;

  // sleep state as reported by software, gray along s0-s1-s3-s45
  typedef enum logic [1:0] {
    SLEEP_S0  = 2'b00,
    SLEEP_S1  = 2'b01,
    SLEEP_S3  = 2'b11,
    SLEEP_S45 = 2'b10
  } sleep_state_type;

endpackage

// >>> hw/status_access_if.sv
/*
  carrier between the bank top and one sticky status row:
  clear strobe bits go in, stored status comes back.
  assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface status_access_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] clear_bits;
  logic [WIDTH-1:0] status;
  modport bank (input clear_bits, output status);
  modport ctrl (output clear_bits, input status);
endinterface

// >>> hw/sticky_status_bits.sv
/*
  a row of sticky error bits with write-one-to-clear.
  assumes event levels and clear bits are on clk_sys; clear bits
  are a one-cycle pulse from the register write decode.
*/
`timescale 1ns/1ps
`include "error_status_params.svh"
module sticky_status_bits #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // already-masked error condition, one per bit
  input  wire logic [WIDTH-1:0] event_level,
  // clear strobes in, status out
  status_access_if.bank         acc
);

  logic [WIDTH-1:0] status_next;

  // a clear only lands where the condition has gone; set beats clear
  assign status_next = (acc.status & ~(acc.clear_bits & ~event_level))
                     | event_level;

  // bits only fall on an accepted clear, never by themselves
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc.status <= WIDTH'(`STATUS_RESET);
    end else begin
      acc.status <= status_next;
    end
  end

endmodule // sticky_status_bits

// >>> hw/throttle_duty_meter.sv
/*
  measures the processor-hot duty over a 256-sample window and holds
  the band and limit flags of the last finished window.
  assumes the hot input is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`include "error_status_params.svh"
module throttle_duty_meter (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // sampling
  input  wire logic       sample_en,
  input  wire logic       hot_sync,
  input  wire logic [7:0] duty_limit,
  // held result of the last window
  output logic      [7:0] duty_flags
);

  logic [8:0] sample_count_reg;
  logic [8:0] hot_count_reg;
  logic [8:0] total;
  logic       last_sample;
  logic [7:0] flags_next;

  // count including the sample taken now
  assign total       = hot_count_reg + {8'h00, hot_sync};
  assign last_sample = sample_count_reg == (`DUTY_WINDOW - 9'h001);

  // band decode of the finished window
  assign flags_next[0] = total != 9'h000;
  assign flags_next[1] = total != 9'h000 && total < `DUTY_12P5;
  assign flags_next[2] = total >= `DUTY_12P5 && total < `DUTY_25;
  assign flags_next[3] = total >= `DUTY_25 && total < `DUTY_50;
  assign flags_next[4] = total >= `DUTY_50 && total < `DUTY_75;
  assign flags_next[5] = total >= `DUTY_75 && total < `DUTY_WINDOW;
  assign flags_next[6] = total == `DUTY_WINDOW;
  assign flags_next[7] = total > {1'b0, duty_limit};

  // window counters; flags hold a full window so clears see a level
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_count_reg <= 9'h000;
      hot_count_reg    <= 9'h000;
      duty_flags       <= `STATUS_RESET;
    end else if (sample_en && last_sample) begin
      sample_count_reg <= 9'h000;
      hot_count_reg    <= 9'h000;
      duty_flags       <= flags_next;
    end else if (sample_en) begin
      sample_count_reg <= sample_count_reg + 9'h001;
      hot_count_reg    <= total;
    end
  end

endmodule // throttle_duty_meter

// >>> hw/error_status_bank.sv
/*
  sticky error status bank: throttle duty bands, general input low
  flags and fan tach limit flags, with sleep masking and the two
  summary bits. registers are reached over the byte register port
  behind the two-wire serial slave.
  assumes the serial slave hands over one byte access per strobe on
  clk_sys, tach values and limits come from clk_sys logic, and the
  hot and general pins are asynchronous.
*/
// Summary of operation
// - any throttling in window sets bit 0
// - duty 0.39 to 12.5 percent sets bit 1
// - duty 12.5 to 25 percent sets bit 2
// - duty 25 to 50 percent sets bit 3
// - duty 50 to 75 percent sets bit 4
// - duty 75 to 100 percent sets bit 5
// - full window throttled sets bit 6
// - duty above user limit sets bit 7
// - only limit bit feeds management summary
// - low unmasked input pin sets its bit
// - tach above limit sets fan bit
// - any input, fan or limit bit sets host summary
// - band flags never reach host summary
// - bits stay set until software clears
// - writing one clears that bit only
// - clear ignored while condition persists
// - sleep state taken from software register
// - per group sleep suppression of events
// - optional sleep masking needs mask bit
`timescale 1ns/1ps
`include "error_status_params.svh"
module error_status_bank #(
  parameter int TACH_WIDTH = 16,
  parameter int SAMPLE_DIV = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // byte register port from the serial slave
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_wr_en,
  input  wire logic [7:0]               reg_wr_data,
  input  wire logic                     reg_rd_en,
  output logic      [7:0]               reg_rd_data,
  output logic                          reg_rd_valid,
  // monitored pins, asynchronous
  input  wire logic                     processor_hot_throttle_input,
  input  wire logic [`INPUT_PINS-1:0]   general_pin,
  // tach measurement and limits, clk_sys domain
  input  wire logic [`FAN_CHANNELS*TACH_WIDTH-1:0] tach_value,
  input  wire logic [`FAN_CHANNELS*TACH_WIDTH-1:0] tach_limit,
  // summary outputs toward the status/control register
  output logic                          host_error_summary,
  output logic                          mgmt_controller_error_summary
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------

  // true when the current sleep state suppresses a group's events
  function automatic logic sleep_suppress(
    input error_status_pkg::sleep_state_type state,
    input logic in_s1,
    input logic in_s3,
    input logic in_s45
  );
    logic hit;
    hit = 1'b0;
    unique case (state)
      error_status_pkg::SLEEP_S0:  hit = 1'b0;
      error_status_pkg::SLEEP_S1:  hit = in_s1;
      error_status_pkg::SLEEP_S3:  hit = in_s3;
      error_status_pkg::SLEEP_S45: hit = in_s45;
    endcase
    return hit;
  endfunction

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------

  logic                   hot_meta_reg;
  logic                   hot_sync_reg;
  logic [`INPUT_PINS-1:0] pin_meta_reg;
  logic [`INPUT_PINS-1:0] pin_sync_reg;

  // two flops each; the first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hot_meta_reg <= 1'b0;
      hot_sync_reg <= 1'b0;
      pin_meta_reg <= {`INPUT_PINS{1'b1}};
      pin_sync_reg <= {`INPUT_PINS{1'b1}};
    end else begin
      hot_meta_reg <= processor_hot_throttle_input;
      hot_sync_reg <= hot_meta_reg;
      pin_meta_reg <= general_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // -------------------------------------------------------------
  // sample rate divider
  // -------------------------------------------------------------

  localparam int DIV_W = $clog2(SAMPLE_DIV + 1);

  logic [DIV_W-1:0] div_count_reg;
  logic             sample_en;

  // one-cycle enable every SAMPLE_DIV clocks
  assign sample_en = div_count_reg == DIV_W'(SAMPLE_DIV - 1);

  always_ff @(posedge clk_sys) begin
    if (reset || sample_en) begin
      div_count_reg <= '0;
    end else begin
      div_count_reg <= div_count_reg + DIV_W'(1);
    end
  end

  // -------------------------------------------------------------
  // register write decode
  // -------------------------------------------------------------

  logic wr_throttle;
  logic wr_input;
  logic wr_fan;
  logic wr_limit;
  logic wr_sleep;
  logic wr_sleep_mask;
  logic wr_input_mask;

  // one strobe per writable offset; other offsets are dropped
  assign wr_throttle   = reg_wr_en && reg_addr == `ADDR_THROTTLE_STATUS;
  assign wr_input      = reg_wr_en && reg_addr == `ADDR_INPUT_STATUS;
  assign wr_fan        = reg_wr_en && reg_addr == `ADDR_FAN_STATUS;
  assign wr_limit      = reg_wr_en && reg_addr == `ADDR_THROTTLE_LIMIT;
  assign wr_sleep      = reg_wr_en && reg_addr == `ADDR_SLEEP_STATE;
  assign wr_sleep_mask = reg_wr_en && reg_addr == `ADDR_SLEEP_MASK;
  assign wr_input_mask = reg_wr_en && reg_addr == `ADDR_INPUT_MASK;

  // -------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------

  logic [7:0]                        limit_reg;
  error_status_pkg::sleep_state_type sleep_reg;
  logic [4:0]                        sleep_mask_reg;
  logic [`INPUT_PINS-1:0]            input_mask_reg;

  // plain read/write; unused high bits are not stored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      limit_reg      <= `LIMIT_RESET;
      sleep_reg      <= error_status_pkg::SLEEP_S0;
      sleep_mask_reg <= 5'h00;
      input_mask_reg <= `STATUS_RESET;
    end else begin
      if (wr_limit) begin
        limit_reg <= reg_wr_data;
      end
      if (wr_sleep) begin
        sleep_reg <= error_status_pkg::sleep_state_type'(reg_wr_data[1:0]);
      end
      if (wr_sleep_mask) begin
        sleep_mask_reg <= reg_wr_data[4:0] & `MASK_USED_BITS;
      end
      if (wr_input_mask) begin
        input_mask_reg <= reg_wr_data;
      end
    end
  end

  // -------------------------------------------------------------
  // sleep suppression per group
  // -------------------------------------------------------------

  logic throttle_quiet;
  logic input_quiet;
  logic fan_quiet;

  // throttle: always in s3 and s45
  assign throttle_quiet = sleep_suppress(sleep_reg, 1'b0, 1'b1, 1'b1);
  // inputs: optional in s1, s3 and s45
  assign input_quiet = sleep_suppress(sleep_reg,
                                      sleep_mask_reg[`MASK_INPUT_S1],
                                      sleep_mask_reg[`MASK_INPUT_S3],
                                      sleep_mask_reg[`MASK_INPUT_S45]);
  // fans: optional in s1 and s3, always in s45
  assign fan_quiet = sleep_suppress(sleep_reg,
                                    sleep_mask_reg[`MASK_FAN_S1],
                                    sleep_mask_reg[`MASK_FAN_S3],
                                    1'b1);

  // -------------------------------------------------------------
  // error conditions
  // -------------------------------------------------------------

  logic [`THROTTLE_BITS-1:0] duty_flags;
  logic [`THROTTLE_BITS-1:0] throttle_event;
  logic [`INPUT_PINS-1:0]    input_event;
  logic [`FAN_CHANNELS-1:0]  fan_event;

  // duty bands and limit of the last finished window
  throttle_duty_meter duty_meter (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .sample_en  (sample_en),
    .hot_sync   (hot_sync_reg),
    .duty_limit (limit_reg),
    .duty_flags (duty_flags)
  );

  assign throttle_event = throttle_quiet ? `STATUS_RESET : duty_flags;

  // a low pin is an error unless its mask bit is set
  assign input_event = input_quiet ? `STATUS_RESET
                                   : ~pin_sync_reg & ~input_mask_reg;

  // one comparator per tach channel
  genvar ch;
  generate
    for (ch = 0; ch < `FAN_CHANNELS; ch = ch + 1) begin : g_tach
      assign fan_event[ch] = !fan_quiet &&
        tach_value[ch*TACH_WIDTH +: TACH_WIDTH] >
        tach_limit[ch*TACH_WIDTH +: TACH_WIDTH];
    end
  endgenerate

  // -------------------------------------------------------------
  // sticky status rows
  // -------------------------------------------------------------

  status_access_if #(.WIDTH(`THROTTLE_BITS)) throttle_acc ();
  status_access_if #(.WIDTH(`INPUT_PINS))    input_acc ();
  status_access_if #(.WIDTH(`FAN_CHANNELS))  fan_acc ();

  // clear strobes: a one clears, a zero leaves the bit alone
  assign throttle_acc.clear_bits = wr_throttle ? reg_wr_data : 8'h00;
  assign input_acc.clear_bits    = wr_input ? reg_wr_data : 8'h00;
  // reserved fan bits 7:4 never reach the row
  assign fan_acc.clear_bits = wr_fan ? reg_wr_data[`FAN_CHANNELS-1:0]
                                     : 4'h0;

  // held until an accepted clear; clears lose to a live condition
  sticky_status_bits #(.WIDTH(`THROTTLE_BITS)) throttle_row (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .event_level (throttle_event),
    .acc         (throttle_acc)
  );

  sticky_status_bits #(.WIDTH(`INPUT_PINS)) input_row (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .event_level (input_event),
    .acc         (input_acc)
  );

  sticky_status_bits #(.WIDTH(`FAN_CHANNELS)) fan_row (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .event_level (fan_event),
    .acc         (fan_acc)
  );

  // -------------------------------------------------------------
  // summary bits
  // -------------------------------------------------------------

  logic host_next;
  logic mgmt_next;

  // band flags 6:0 stay out of both summaries on purpose
  assign host_next = throttle_acc.status[`THROTTLE_LIMIT_BIT]
                   | (|input_acc.status)
                   | (|fan_acc.status);
  assign mgmt_next = throttle_acc.status[`THROTTLE_LIMIT_BIT];

  // registered, so the summaries trail the status by one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      host_error_summary            <= 1'b0;
      mgmt_controller_error_summary <= 1'b0;
    end else begin
      host_error_summary            <= host_next;
      mgmt_controller_error_summary <= mgmt_next;
    end
  end

  // -------------------------------------------------------------
  // register read path
  // -------------------------------------------------------------

  logic [7:0] rd_mux;

  // unmapped offsets and reserved bits read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `ADDR_THROTTLE_STATUS: rd_mux = throttle_acc.status;
      `ADDR_INPUT_STATUS:    rd_mux = input_acc.status;
      `ADDR_FAN_STATUS:      rd_mux = {4'h0, fan_acc.status};
      `ADDR_THROTTLE_LIMIT:  rd_mux = limit_reg;
      `ADDR_SLEEP_STATE:     rd_mux = {6'h00, sleep_reg};
      `ADDR_SLEEP_MASK:      rd_mux = {3'h0, sleep_mask_reg};
      `ADDR_INPUT_MASK:      rd_mux = input_mask_reg;
      `ADDR_SUMMARY:         rd_mux = {6'h00, mgmt_next, host_next};
      default:               rd_mux = 8'h00;
    endcase
  end

  // data captured on the strobe and held until the next read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_mux;
      end
    end
  end

endmodule // error_status_bank

// >>> sim/error_status_bank_chk.sv
/*
  port checker for the sticky error status bank.
  assumes it is bound to error_status_bank and sees only its ports.
*/
`timescale 1ns/1ps
`include "error_status_params.svh"
module error_status_bank_chk #(
  parameter int TACH_WIDTH = 16,
  parameter int SAMPLE_DIV = 50
) (
  // clock and reset
  input wire logic                                 clk_sys,
  input wire logic                                 reset,
  // register port
  input wire logic [7:0]                           reg_addr,
  input wire logic                                 reg_wr_en,
  input wire logic [7:0]                           reg_wr_data,
  input wire logic                                 reg_rd_en,
  input wire logic [7:0]                           reg_rd_data,
  input wire logic                                 reg_rd_valid,
  // monitored inputs
  input wire logic                                 processor_hot_throttle_input,
  input wire logic [`INPUT_PINS-1:0]               general_pin,
  input wire logic [`FAN_CHANNELS*TACH_WIDTH-1:0]  tach_value,
  input wire logic [`FAN_CHANNELS*TACH_WIDTH-1:0]  tach_limit,
  // summaries
  input wire logic                                 host_error_summary,
  input wire logic                                 mgmt_controller_error_summary
);
  logic [1:0] sleep_reg;
  logic [7:0] pin_mask_reg;
  logic       status_wr_reg;
  // -----------------------------------------------------------
  // shadow of the software state the rules depend on
  // -----------------------------------------------------------
  wire status_wr = reg_wr_en && (reg_addr == `ADDR_THROTTLE_STATUS ||
    reg_addr == `ADDR_INPUT_STATUS || reg_addr == `ADDR_FAN_STATUS);
  wire mapped = reg_addr == `ADDR_THROTTLE_STATUS || reg_addr == `ADDR_INPUT_STATUS ||
    reg_addr == `ADDR_FAN_STATUS || (reg_addr >= 8'h50 && reg_addr <= 8'h54);
  // shadows follow writes so sleep-dependent checks stay quiet outside s0
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sleep_reg     <= 2'h0;
      pin_mask_reg  <= 8'h00;
      status_wr_reg <= 1'b0;
    end else begin
      if (reg_wr_en && reg_addr == `ADDR_SLEEP_STATE) sleep_reg <= reg_wr_data[1:0];
      if (reg_wr_en && reg_addr == `ADDR_INPUT_MASK) pin_mask_reg <= reg_wr_data;
      status_wr_reg <= status_wr;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe gave no valid pulse");
  rd_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("valid pulse without read strobe");
  unmapped_zero_a: assert property (reg_rd_en && !mapped |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  fan_reserved_a: assert property (reg_rd_en && reg_addr == `ADDR_FAN_STATUS
    |=> reg_rd_data[7:4] == 4'h0) else $error("fan reserved bits not zero");
  mgmt_matches_a: assert property (reg_rd_en && reg_addr == `ADDR_THROTTLE_STATUS
    |=> mgmt_controller_error_summary == reg_rd_data[7]) else $error("mgmt summary mismatch");
  fan_to_host_a: assert property (reg_rd_en && reg_addr == `ADDR_FAN_STATUS
    ##1 reg_rd_data != 8'h00 |-> host_error_summary) else $error("fan bit without host summary");
  mgmt_host_a: assert property (mgmt_controller_error_summary |-> host_error_summary)
    else $error("limit error missing from host summary");
  host_sticky_a: assert property (host_error_summary && !status_wr_reg
    |=> host_error_summary) else $error("host summary dropped without a clear");
  fan_set_a: assert property ((tach_value[TACH_WIDTH-1:0] > tach_limit[TACH_WIDTH-1:0])
    && sleep_reg == 2'h0 |-> ##2 host_error_summary) else $error("fan over limit not flagged");
  pin_set_a: assert property ((!general_pin[3] && !pin_mask_reg[3] && sleep_reg == 2'h0)
    [*4] |=> host_error_summary) else $error("low pin not flagged");
endmodule // error_status_bank_chk

bind error_status_bank error_status_bank_chk #(.TACH_WIDTH(TACH_WIDTH), .SAMPLE_DIV(SAMPLE_DIV))
  error_status_bank_chk_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .processor_hot_throttle_input(processor_hot_throttle_input), .general_pin(general_pin),
  .tach_value(tach_value), .tach_limit(tach_limit), .host_error_summary(host_error_summary),
  .mgmt_controller_error_summary(mgmt_controller_error_summary));

// >>> sim/tb_error_status_bank.sv
/*
  self-checking bench for the sticky error status bank.
  assumes the bank top with a shortened sample divider of 2.
*/
`timescale 1ns/1ps
`include "error_status_params.svh"
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_error_status_bank;
  logic        clk_sys;
  logic        reset;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wr_data;
  logic        reg_rd_en;
  logic [7:0]  reg_rd_data;
  logic        reg_rd_valid;
  logic        hot;
  logic [7:0]  general_pin;
  logic [63:0] tach_value;
  logic [63:0] tach_limit;
  logic        host_sum;
  logic        mgmt_sum;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  error_status_bank #(.TACH_WIDTH(16), .SAMPLE_DIV(2)) error_status_bank_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .processor_hot_throttle_input(hot),
    .general_pin(general_pin), .tach_value(tach_value), .tach_limit(tach_limit),
    .host_error_summary(host_sum), .mgmt_controller_error_summary(mgmt_sum));

  // 50 MHz clock and a hang guard well above the longest run
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  // -----------------------------------------------------------
  // register port and pin helpers, all driven at falling edges
  // -----------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    `CHK("read valid", 1'b1, reg_rd_valid)
    `CHK(nm, e, reg_rd_data)
  endtask
  // one count above the limit for two clocks, then back to equal
  task automatic fan_pulse(input int ch);
    tach_value[ch*16 +: 16] = tach_limit[ch*16 +: 16] + 16'h0001;
    idle(2);
    tach_value[ch*16 +: 16] = tach_limit[ch*16 +: 16];
    idle(2);
  endtask
  // period divides the window, so every window sees the same count
  task automatic run_hot(input int pls, input int per, input int n);
    for (int c = 0; c < n; c++) begin
      hot = (c % per) < pls;
      @(negedge clk_sys);
    end
  endtask

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic test_reset_values();
    logic [7:0] a [8];
    logic [7:0] e [8];
    a = '{8'h44, 8'h46, 8'h47, 8'h50, 8'h51, 8'h52, 8'h53, 8'h45};
    e = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd_chk("reset value", a[i], e[i]);
    `CHK("host after reset", 1'b0, host_sum)
  endtask

  task automatic test_input_pins();
    general_pin[3] = 1'b0;
    idle(5);
    rd_chk("pin low", `ADDR_INPUT_STATUS, 8'h08);
    `CHK("host on pin", 1'b1, host_sum)
    wr(`ADDR_INPUT_STATUS, 8'h08);
    rd_chk("clear while low", `ADDR_INPUT_STATUS, 8'h08);
    general_pin[3] = 1'b1;
    idle(5);
    rd_chk("held after release", `ADDR_INPUT_STATUS, 8'h08);
    wr(`ADDR_INPUT_STATUS, 8'hf7);
    rd_chk("zero write kept", `ADDR_INPUT_STATUS, 8'h08);
    wr(`ADDR_INPUT_STATUS, 8'h08);
    idle(2);
    rd_chk("pin cleared", `ADDR_INPUT_STATUS, 8'h00);
    `CHK("host cleared", 1'b0, host_sum)
    wr(`ADDR_INPUT_MASK, 8'h04);
    general_pin[2] = 1'b0;
    idle(5);
    rd_chk("masked pin", `ADDR_INPUT_STATUS, 8'h00);
    general_pin[2] = 1'b1;
    idle(4);
    wr(`ADDR_INPUT_MASK, 8'h00);
  endtask

  task automatic test_fan();
    idle(3);
    rd_chk("fan at limit", `ADDR_FAN_STATUS, 8'h00);
    for (int ch = 0; ch < 4; ch++) begin
      fan_pulse(ch);
      rd_chk("fan over", `ADDR_FAN_STATUS, 8'((1 << (ch + 1)) - 1));
    end
    `CHK("mgmt from fan", 1'b0, mgmt_sum)
    wr(`ADDR_FAN_STATUS, 8'hff);
    rd_chk("fan cleared", `ADDR_FAN_STATUS, 8'h00);
  endtask

  task automatic test_sleep();
    wr(`ADDR_SLEEP_STATE, 8'h02);
    fan_pulse(0);
    rd_chk("fan in s45", `ADDR_FAN_STATUS, 8'h00);
    wr(`ADDR_SLEEP_STATE, 8'h01);
    fan_pulse(1);
    rd_chk("fan s1 open", `ADDR_FAN_STATUS, 8'h02);
    wr(`ADDR_FAN_STATUS, 8'hff);
    wr(`ADDR_SLEEP_MASK, 8'h08);
    fan_pulse(1);
    rd_chk("fan s1 masked", `ADDR_FAN_STATUS, 8'h00);
    wr(`ADDR_SLEEP_STATE, 8'h03);
    wr(`ADDR_SLEEP_MASK, 8'h02);
    general_pin[0] = 1'b0;
    idle(5);
    rd_chk("pin s3 masked", `ADDR_INPUT_STATUS, 8'h00);
    general_pin[0] = 1'b1;
    idle(4);
    rd_chk("sleep readback", `ADDR_SLEEP_STATE, 8'h03);
    wr(`ADDR_SLEEP_STATE, 8'h00);
    wr(`ADDR_SLEEP_MASK, 8'h00);
  endtask

  // counts 1, 32, 96, 160, 224, 256 against a limit of 95
  task automatic test_throttle();
    int         pls [6];
    int         per [6];
    logic [7:0] e [6];
    pls = '{2, 2, 6, 10, 14, 16};
    per = '{512, 16, 16, 16, 16, 16};
    e = '{8'h03, 8'h05, 8'h89, 8'h91, 8'ha1, 8'hc1};
    wr(`ADDR_THROTTLE_LIMIT, 8'h5f);
    for (int i = 0; i < 6; i++) begin
      run_hot(pls[i], per[i], 1536);
      wr(`ADDR_THROTTLE_STATUS, 8'hff);
      rd_chk("band held", `ADDR_THROTTLE_STATUS, e[i]);
      rd_chk("summary reg", `ADDR_SUMMARY, {6'h00, e[i][7], e[i][7]});
      `CHK("mgmt summary", e[i][7], mgmt_sum)
      `CHK("host summary", e[i][7], host_sum)
      hot = 1'b0;
      idle(1536);
      wr(`ADDR_THROTTLE_STATUS, 8'hff);
      rd_chk("band cleared", `ADDR_THROTTLE_STATUS, 8'h00);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    hot = 1'b0;
    general_pin = 8'hff;
    tach_limit = {16'h0400, 16'h0300, 16'h0200, 16'h0100};
    tach_value = tach_limit;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    test_reset_values();
    test_input_pins();
    test_fan();
    test_sleep();
    test_throttle();
    print_verdict();
  end
endmodule // tb_error_status_bank
